// [prx_regs.vh]
`ifndef PRX_REGS_VH
`define PRX_REGS_VH

// Register addresses
`define PRX_ADDR_PROX_HIGH      8'h87
`define PRX_ADDR_PROX_LOW       8'h88
`define PRX_ADDR_IRQ_CTRL       8'h89
`define PRX_ADDR_LOW_THR_HIGH   8'h8A
`define PRX_ADDR_LOW_THR_LOW    8'h8B
`define PRX_ADDR_HIGH_THR_HIGH  8'h8C
`define PRX_ADDR_HIGH_THR_LOW   8'h8D
`define PRX_ADDR_IRQ_STATUS     8'h8E

// Interrupt control fields
`define PRX_CTRL_PERSIST_MSB    7
`define PRX_CTRL_PERSIST_LSB    5
`define PRX_CTRL_PROX_EN_BIT    3
`define PRX_CTRL_ALS_EN_BIT     2
`define PRX_CTRL_LIMIT_EN_BIT   1
`define PRX_CTRL_SRC_SEL_BIT    0

// Interrupt status fields
`define PRX_STAT_PROX_BIT       3
`define PRX_STAT_ALS_BIT        2
`define PRX_STAT_BELOW_BIT      1
`define PRX_STAT_ABOVE_BIT      0

// Reset values
`define PRX_RST_BYTE            8'h00
`define PRX_RST_WORD            16'h0000
`define PRX_RST_FLAGS           4'h0
`define PRX_RST_COUNT           8'h00

// Misc constants
`define PRX_COUNT_ONE           8'h01
`define PRX_SRC_PROX            1'b0
`define PRX_PIN_LOW             1'b0

`endif

// [prx_persist.v]
`timescale 1ns/1ps
`include "prx_regs.vh"

// Counts consecutive out-of-window samples in one direction
module prx_persist #(
    parameter CNT_W = 8
) (
    // Clock and reset
    input  wire             clk_i,
    input  wire             resetn_i,
    // Sample stream
    input  wire             restart_i,
    input  wire             sample_i,
    input  wire             hit_i,
    input  wire [CNT_W-1:0] need_i,
    // Event
    output reg              fire_o
);

    reg  [CNT_W-1:0] count;
    wire [CNT_W-1:0] count_inc;

    assign count_inc = count + `PRX_COUNT_ONE;

    always @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            count  <= `PRX_RST_COUNT;
            fire_o <= 1'b0;
        end
        else
        begin
            fire_o <= 1'b0;
            if (restart_i)
            begin
                count <= `PRX_RST_COUNT;
            end
            else if (sample_i)
            begin
                if (!hit_i)
                begin
                    count <= `PRX_RST_COUNT;
                end
                else if (count_inc == need_i)
                begin
                    // Restart after firing so a persisting level fires again every full run
                    count  <= `PRX_RST_COUNT;
                    fire_o <= 1'b1;
                end
                else
                begin
                    count <= count_inc;
                end
            end
        end
    end

endmodule // prx_persist

// [prx_core.v]
`timescale 1ns/1ps
`include "prx_regs.vh"

module prx_core #(
    parameter DATA_W = 16,
    parameter CNT_W  = 8
) (
    // Clock and reset
    input  wire              clk_i,
    input  wire              resetn_i,
    // Register port from the serial front end
    input  wire [7:0]        reg_addr_i,
    input  wire              reg_wr_i,
    input  wire [7:0]        reg_wdata_i,
    input  wire              reg_rd_i,
    output reg  [7:0]        reg_rdata_o,
    // Measurement results
    input  wire              prox_valid_i,
    input  wire [DATA_W-1:0] prox_data_i,
    input  wire              als_valid_i,
    input  wire [DATA_W-1:0] als_data_i,
    // Open-drain interrupt pin
    input  wire              irq_pad_i,
    output wire              irq_pad_o,
    output wire              irq_pad_oe_o
);

    // Register state
    reg  [DATA_W-1:0] prox_result;
    reg  [7:0]        irq_ctrl;
    reg  [DATA_W-1:0] low_thr;
    reg  [DATA_W-1:0] high_thr;
    reg               prox_ready_flag;
    reg               als_ready_flag;
    reg               below_limit_flag;
    reg               above_limit_flag;
    reg  [7:0]        next_rdata;

    // Control decode
    wire [2:0]        persist_sel;
    wire              prox_irq_en;
    wire              als_irq_en;
    wire              limit_irq_en;
    wire              limit_source_sel;
    wire [CNT_W-1:0]  persist_need;

    // Threshold path
    wire              cmp_valid;
    wire [DATA_W-1:0] cmp_data;
    wire              cmp_below;
    wire              cmp_above;
    wire              below_fire;
    wire              above_fire;
    wire              persist_restart;

    // Host access strobes
    wire              wr_ctrl;
    wire              wr_status;
    wire [3:0]        status_vec;

    assign persist_sel      = irq_ctrl[`PRX_CTRL_PERSIST_MSB:`PRX_CTRL_PERSIST_LSB];
    assign prox_irq_en      = irq_ctrl[`PRX_CTRL_PROX_EN_BIT];
    assign als_irq_en       = irq_ctrl[`PRX_CTRL_ALS_EN_BIT];
    assign limit_irq_en     = irq_ctrl[`PRX_CTRL_LIMIT_EN_BIT];
    assign limit_source_sel = irq_ctrl[`PRX_CTRL_SRC_SEL_BIT];

    // Required run length is a power of two of the field value
    assign persist_need = {{(CNT_W-1){1'b0}}, 1'b1} << persist_sel;

    // Pick the stream the thresholds are applied to
    assign cmp_valid = (limit_source_sel == `PRX_SRC_PROX) ? prox_valid_i : als_valid_i;
    assign cmp_data  = (limit_source_sel == `PRX_SRC_PROX) ? prox_data_i  : als_data_i;

    assign cmp_below = cmp_data < low_thr;
    assign cmp_above = cmp_data > high_thr;

    // Reprogramming the control register or disabling the limit check
    // discards a partly counted run, so stale samples never count
    assign persist_restart = !limit_irq_en || wr_ctrl;

    assign wr_ctrl   = reg_wr_i && (reg_addr_i == `PRX_ADDR_IRQ_CTRL);
    assign wr_status = reg_wr_i && (reg_addr_i == `PRX_ADDR_IRQ_STATUS);

    prx_persist #(
        .CNT_W (CNT_W)
    ) u_below (
        .clk_i     (clk_i),
        .resetn_i  (resetn_i),
        .restart_i (persist_restart),
        .sample_i  (cmp_valid),
        .hit_i     (cmp_below),
        .need_i    (persist_need),
        .fire_o    (below_fire)
    );

    prx_persist #(
        .CNT_W (CNT_W)
    ) u_above (
        .clk_i     (clk_i),
        .resetn_i  (resetn_i),
        .restart_i (persist_restart),
        .sample_i  (cmp_valid),
        .hit_i     (cmp_above),
        .need_i    (persist_need),
        .fire_o    (above_fire)
    );

    // Measurement result capture; the host has no write path here
    always @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            prox_result <= `PRX_RST_WORD;
        end
        else if (prox_valid_i)
        begin
            prox_result <= prox_data_i;
        end
    end

    // Host-writable configuration
    always @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            irq_ctrl <= `PRX_RST_BYTE;
            low_thr  <= `PRX_RST_WORD;
            high_thr <= `PRX_RST_WORD;
        end
        else if (reg_wr_i)
        begin
            if (reg_addr_i == `PRX_ADDR_IRQ_CTRL)
            begin
                irq_ctrl <= reg_wdata_i;
            end
            else if (reg_addr_i == `PRX_ADDR_LOW_THR_HIGH)
            begin
                low_thr[15:8] <= reg_wdata_i;
            end
            else if (reg_addr_i == `PRX_ADDR_LOW_THR_LOW)
            begin
                low_thr[7:0] <= reg_wdata_i;
            end
            else if (reg_addr_i == `PRX_ADDR_HIGH_THR_HIGH)
            begin
                high_thr[15:8] <= reg_wdata_i;
            end
            else if (reg_addr_i == `PRX_ADDR_HIGH_THR_LOW)
            begin
                high_thr[7:0] <= reg_wdata_i;
            end
        end
    end

    // Sticky status: a new event beats a same-cycle host clear
    always @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            prox_ready_flag  <= 1'b0;
            als_ready_flag   <= 1'b0;
            below_limit_flag <= 1'b0;
            above_limit_flag <= 1'b0;
        end
        else
        begin
            if (prox_valid_i && prox_irq_en)
            begin
                prox_ready_flag <= 1'b1;
            end
            else if (wr_status && reg_wdata_i[`PRX_STAT_PROX_BIT])
            begin
                prox_ready_flag <= 1'b0;
            end

            if (als_valid_i && als_irq_en)
            begin
                als_ready_flag <= 1'b1;
            end
            else if (wr_status && reg_wdata_i[`PRX_STAT_ALS_BIT])
            begin
                als_ready_flag <= 1'b0;
            end

            if (below_fire && limit_irq_en)
            begin
                below_limit_flag <= 1'b1;
            end
            else if (wr_status && reg_wdata_i[`PRX_STAT_BELOW_BIT])
            begin
                below_limit_flag <= 1'b0;
            end

            if (above_fire && limit_irq_en)
            begin
                above_limit_flag <= 1'b1;
            end
            else if (wr_status && reg_wdata_i[`PRX_STAT_ABOVE_BIT])
            begin
                above_limit_flag <= 1'b0;
            end
        end
    end

    assign status_vec = {prox_ready_flag, als_ready_flag, below_limit_flag, above_limit_flag};

    // Read mux
    always @*
    begin
        next_rdata = `PRX_RST_BYTE;
        if (reg_addr_i == `PRX_ADDR_PROX_HIGH)
        begin
            next_rdata = prox_result[15:8];
        end
        else if (reg_addr_i == `PRX_ADDR_PROX_LOW)
        begin
            next_rdata = prox_result[7:0];
        end
        else if (reg_addr_i == `PRX_ADDR_IRQ_CTRL)
        begin
            next_rdata = irq_ctrl;
        end
        else if (reg_addr_i == `PRX_ADDR_LOW_THR_HIGH)
        begin
            next_rdata = low_thr[15:8];
        end
        else if (reg_addr_i == `PRX_ADDR_LOW_THR_LOW)
        begin
            next_rdata = low_thr[7:0];
        end
        else if (reg_addr_i == `PRX_ADDR_HIGH_THR_HIGH)
        begin
            next_rdata = high_thr[15:8];
        end
        else if (reg_addr_i == `PRX_ADDR_HIGH_THR_LOW)
        begin
            next_rdata = high_thr[7:0];
        end
        else if (reg_addr_i == `PRX_ADDR_IRQ_STATUS)
        begin
            next_rdata = {4'h0, status_vec};
        end
    end

    // Read data is held until the next read so the front end may shift it out slowly
    always @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            reg_rdata_o <= `PRX_RST_BYTE;
        end
        else if (reg_rd_i)
        begin
            reg_rdata_o <= next_rdata;
        end
    end

    // Open drain: only ever pulls low; the pad level input is not needed internally
    assign irq_pad_o    = `PRX_PIN_LOW;
    assign irq_pad_oe_o = |status_vec;

endmodule // prx_core

// [prx_core_assertions.sv]
`timescale 1ns/1ps
module prx_core_assertions #(
    parameter DATA_W = 16
) (
    // Clock and reset
    input logic              clk_i,
    input logic              resetn_i,
    // Register port
    input logic [7:0]        reg_addr_i,
    input logic              reg_wr_i,
    input logic [7:0]        reg_wdata_i,
    input logic              reg_rd_i,
    input logic [7:0]        reg_rdata_o,
    // Measurements
    input logic              prox_valid_i,
    input logic [DATA_W-1:0] prox_data_i,
    input logic              als_valid_i,
    input logic [DATA_W-1:0] als_data_i,
    // Interrupt pad
    input logic              irq_pad_i,
    input logic              irq_pad_o,
    input logic              irq_pad_oe_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!resetn_i);

    // A limit flag lands two edges after its sample, so two quiet cycles would do; three are required
    sequence quiet_s;
        (!prox_valid_i && !als_valid_i) [*3];
    endsequence
    sequence clear_all_s;
        reg_wr_i && reg_addr_i == 8'h8E && reg_wdata_i[3:0] == 4'hF;
    endsequence

    pad_drive_low_a: assert property (irq_pad_o == 1'b0)
        else $error("irq pad output not low");
    clear_all_a: assert property (quiet_s ##0 clear_all_s |=> !irq_pad_oe_o)
        else $error("irq still active after clearing all flags");
    flag_sticky_a: assert property (irq_pad_oe_o && !(reg_wr_i && reg_addr_i == 8'h8E) |=> irq_pad_oe_o)
        else $error("irq dropped without a clear");
    rise_cause_a: assert property ($rose(irq_pad_oe_o) |-> $past(prox_valid_i || als_valid_i)
        || $past(prox_valid_i || als_valid_i, 2)) else $error("irq rose without a measurement");
    read_hold_a: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
        else $error("read data changed without a read");
    prox_read_a: assert property (prox_valid_i ##1 (reg_rd_i && reg_addr_i == 8'h87)
        |=> reg_rdata_o == $past(prox_data_i[15:8], 2)) else $error("proximity high byte wrong");
    low_thr_read_a: assert property (reg_wr_i && reg_addr_i == 8'h8A ##1
        (reg_rd_i && !reg_wr_i && reg_addr_i == 8'h8A) |=> reg_rdata_o == $past(reg_wdata_i, 2))
        else $error("low threshold readback wrong");
    unmapped_read_a: assert property (reg_rd_i && (reg_addr_i < 8'h87 || reg_addr_i > 8'h8E)
        |=> reg_rdata_o == 8'h00) else $error("unmapped read not zero");
    status_read_a: assert property (reg_rd_i && reg_addr_i == 8'h8E
        |=> reg_rdata_o[7:4] == 4'h0 && (reg_rdata_o[3:0] != 4'h0) == $past(irq_pad_oe_o))
        else $error("status read disagrees with irq pad");
endmodule // prx_core_assertions

bind prx_core prx_core_assertions #(.DATA_W(DATA_W)) chk_u (
    .clk_i(clk_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
    .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .prox_valid_i(prox_valid_i), .prox_data_i(prox_data_i), .als_valid_i(als_valid_i),
    .als_data_i(als_data_i), .irq_pad_i(irq_pad_i), .irq_pad_o(irq_pad_o), .irq_pad_oe_o(irq_pad_oe_o)
);

// [prx_host.sv]
`timescale 1ns/1ps
module prx_host (
    // Clock
    input  logic       clk_i,
    // Register port
    output logic [7:0] reg_addr_o,
    output logic       reg_wr_o,
    output logic [7:0] reg_wdata_o,
    output logic       reg_rd_o,
    input  logic [7:0] reg_rdata_i
);
    initial
    begin
        reg_addr_o  = 8'h00;
        reg_wr_o    = 1'b0;
        reg_wdata_o = 8'h00;
        reg_rd_o    = 1'b0;
    end
    // Called at a falling edge; strobe stays up so accesses can run back to back
    task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
        reg_addr_o  = a;
        reg_wdata_o = d;
        reg_wr_o    = wr;
        reg_rd_o    = !wr;
        @(negedge clk_i);
        q = reg_rdata_i;
    endtask
    // Released lines show inverted values so stale data never looks valid
    task automatic idle();
        reg_wr_o    = 1'b0;
        reg_rd_o    = 1'b0;
        reg_addr_o  = ~reg_addr_o;
        reg_wdata_o = ~reg_wdata_o;
        @(negedge clk_i);
    endtask
endmodule // prx_host

// [tb_top.sv]
`timescale 1ns/1ps
module tb_top;
    logic        clk_i      = 1'b0;
    logic        resetn_i   = 1'b0;
    logic [7:0]  reg_addr;
    logic        reg_wr;
    logic [7:0]  reg_wdata;
    logic        reg_rd;
    logic [7:0]  reg_rdata;
    logic        prox_valid = 1'b0;
    logic [15:0] prox_data  = 16'h0000;
    logic        als_valid  = 1'b0;
    logic [15:0] als_data   = 16'h0000;
    logic        pad_out;
    logic        pad_oe;
    wire         pad        = pad_oe ? pad_out : 1'b1;
    int          miscompares = 0;
    int          n_compared  = 0;
    int          cyc         = 0;

    always #12.5 clk_i = ~clk_i;

    prx_core #(.DATA_W(16), .CNT_W(8)) dut_u (
        .clk_i(clk_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr), .reg_wr_i(reg_wr),
        .reg_wdata_i(reg_wdata), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata),
        .prox_valid_i(prox_valid), .prox_data_i(prox_data), .als_valid_i(als_valid),
        .als_data_i(als_data), .irq_pad_i(pad), .irq_pad_o(pad_out), .irq_pad_oe_o(pad_oe)
    );
    prx_host host_u (
        .clk_i(clk_i), .reg_addr_o(reg_addr), .reg_wr_o(reg_wr), .reg_wdata_o(reg_wdata),
        .reg_rd_o(reg_rd), .reg_rdata_i(reg_rdata)
    );

    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        host_u.access(1'b1, a, d, q);
        host_u.idle();
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] q;
        host_u.access(1'b0, a, 8'h00, q);
        host_u.idle();
        chk(q, exp);
    endtask
    task automatic pad_chk(input logic exp);
        @(negedge clk_i);
        chk({7'h00, pad}, {7'h00, exp});
    endtask
    task automatic sample(input logic als, input logic [15:0] d);
        prox_valid = !als;
        als_valid  = als;
        prox_data  = d;
        als_data   = d;
        @(negedge clk_i);
        prox_valid = 1'b0;
        als_valid  = 1'b0;
        prox_data  = ~d;
        als_data   = ~d;
        @(negedge clk_i);
    endtask

    task automatic t_reset();
        for (int a = 8'h87; a <= 8'h8E; a++)
            rd_chk(a[7:0], 8'h00);
        rd_chk(8'h90, 8'h00);
    endtask
    task automatic t_regs();
        logic [7:0] q;
        for (int a = 8'h8A; a <= 8'h8D; a++)
            wr(a[7:0], a[7:0] ^ 8'h5A);
        for (int a = 8'h8A; a <= 8'h8D; a++)
            rd_chk(a[7:0], a[7:0] ^ 8'h5A);
        host_u.access(1'b1, 8'h8A, 8'h3C, q);
        host_u.access(1'b0, 8'h8A, 8'h00, q);
        host_u.idle();
        chk(q, 8'h3C);
        wr(8'h87, 8'hFF);
        wr(8'h88, 8'hFF);
        rd_chk(8'h87, 8'h00);
        rd_chk(8'h88, 8'h00);
    endtask
    task automatic t_ready();
        logic [7:0] q;
        logic [7:0] r;
        wr(8'h89, 8'h08);
        prox_valid = 1'b1;
        prox_data  = 16'hA55A;
        @(negedge clk_i);
        prox_valid = 1'b0;
        prox_data  = 16'h5AA5;
        host_u.access(1'b0, 8'h87, 8'h00, q);
        host_u.access(1'b0, 8'h88, 8'h00, r);
        host_u.idle();
        chk(q, 8'hA5);
        chk(r, 8'h5A);
        pad_chk(1'b0);
        rd_chk(8'h8E, 8'h08);
        wr(8'h8E, 8'h08);
        pad_chk(1'b1);
        sample(1'b1, 16'h0001);
        pad_chk(1'b1);
        wr(8'h89, 8'h04);
        sample(1'b1, 16'h0001);
        rd_chk(8'h8E, 8'h04);
        // New event and host clear on one edge: the event must win
        als_valid = 1'b1;
        host_u.access(1'b1, 8'h8E, 8'h04, q);
        als_valid = 1'b0;
        host_u.idle();
        rd_chk(8'h8E, 8'h04);
        wr(8'h8E, 8'h0F);
        pad_chk(1'b1);
    endtask
    task automatic t_limit();
        wr(8'h8A, 8'h01);
        wr(8'h8B, 8'h00);
        wr(8'h8C, 8'h02);
        wr(8'h8D, 8'h00);
        wr(8'h89, 8'h22);
        sample(1'b0, 16'h00FF);
        sample(1'b0, 16'h0150);
        sample(1'b0, 16'h00FF);
        pad_chk(1'b1);
        sample(1'b0, 16'h00FF);
        pad_chk(1'b0);
        rd_chk(8'h8E, 8'h02);
        wr(8'h8E, 8'h0F);
        wr(8'h89, 8'h23);
        sample(1'b0, 16'hFFFF);
        sample(1'b0, 16'hFFFF);
        pad_chk(1'b1);
        sample(1'b1, 16'h0201);
        sample(1'b1, 16'h0201);
        rd_chk(8'h8E, 8'h01);
        wr(8'h8E, 8'h0F);
        wr(8'h89, 8'hE2);
        rd_chk(8'h89, 8'hE2);
        repeat (127) sample(1'b0, 16'h0000);
        pad_chk(1'b1);
        sample(1'b0, 16'h0000);
        pad_chk(1'b0);
        wr(8'h89, 8'h00);
        wr(8'h8E, 8'h0F);
        sample(1'b0, 16'h0000);
        pad_chk(1'b1);
    endtask

    initial
    begin
        repeat (5) @(negedge clk_i);
        resetn_i = 1'b1;
        t_reset();
        t_regs();
        t_ready();
        t_limit();
        results();
    end
    // Whole run needs well under 1000 cycles
    always @(posedge clk_i)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            miscompares++;
            results();
        end
    end
endmodule // tb_top
